//--- rtl/tsp_pkg.sv
/*
  constants and types shared by the serial configuration port files.
  assumes nothing of its surroundings; included by package name only.
*/
package tsp_pkg;
  // ----------------------------------------------------------------
  // register bus map (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int EV_W = 3;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;
  localparam int EV_DONE_BIT = 0;
  localparam int EV_ABORT_BIT = 1;
  localparam int EV_STROBE_BIT = 2;
  localparam int VIEW_HDR_LSB = 8;
  // ----------------------------------------------------------------
  // serial header and status byte layout
  // ----------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam int HDR_RW_BIT = 7;
  localparam int HDR_BURST_BIT = 6;
  localparam logic [5:0] STROBE_LO = 6'h30;
  localparam logic [5:0] STROBE_HI = 6'h3D;
  localparam int STAT_RDY_BIT = 7;
  localparam int STAT_STATE_LSB = 4;
  localparam int STAT_FIFO_LSB = 0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // ----------------------------------------------------------------
  // port phases
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_HDR = 2'b01,
    PH_DATA = 2'b10
  } tsp_phase_type;
endpackage

//--- rtl/tsp_sync.sv
/*
  three-stage pin synchroniser with agreement filter.
  assumes an asynchronous input and one core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tsp_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  output logic level_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } tsp_sync_type;
  tsp_sync_type st_reg;
  tsp_sync_type st_next;

  // first stage feeds only the second; level moves when stages 2 and 3 agree
  always_comb begin
    st_next = st_reg;
    st_next.s1 = pin_i;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (st_reg.s2 == st_reg.s3) begin
      st_next.lvl = st_reg.s3;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_o = st_reg.lvl;
endmodule
`default_nettype wire

//--- rtl/tsp_wb_regs.sv
/*
  classic wishbone slave: control, status view, sticky events, mask.
  assumes one-cycle event pulses and a single core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tsp_wb_regs (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [tsp_pkg::EV_W-1:0] ev_i,
  input wire logic [15:0] view_i,
  output logic port_en_o,
  output logic irq_o
);
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic en;
    logic [tsp_pkg::EV_W-1:0] stat;
    logic [tsp_pkg::EV_W-1:0] mask;
    logic irq;
  } tsp_wb_type;
  tsp_wb_type st_reg;
  tsp_wb_type st_next;
  logic hit;
  logic [tsp_pkg::EV_W-1:0] clr;

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  // answer one cycle after the strobe; unmapped reads give zero
  always_comb begin
    st_next = st_reg;
    hit = wb_cyc_i & wb_stb_i & ~st_reg.ack;
    clr = '0;
    st_next.ack = hit;
    st_next.dat = 32'h0000_0000;
    if (hit && wb_we_i && wb_sel_i[0]) begin
      case (wb_adr_i)
        tsp_pkg::CTRL_OFS: st_next.en = wb_dat_i[tsp_pkg::CTRL_EN_BIT];
        tsp_pkg::IRQ_STAT_OFS: clr = wb_dat_i[tsp_pkg::EV_W-1:0];
        tsp_pkg::IRQ_MASK_OFS: st_next.mask = wb_dat_i[tsp_pkg::EV_W-1:0];
        default: ;
      endcase
    end
    if (hit && !wb_we_i) begin
      case (wb_adr_i)
        tsp_pkg::CTRL_OFS: st_next.dat[tsp_pkg::CTRL_EN_BIT] = st_reg.en;
        tsp_pkg::STAT_OFS: st_next.dat[15:0] = view_i;
        tsp_pkg::IRQ_STAT_OFS: st_next.dat[tsp_pkg::EV_W-1:0] = st_reg.stat;
        tsp_pkg::IRQ_MASK_OFS: st_next.dat[tsp_pkg::EV_W-1:0] = st_reg.mask;
        default: ;
      endcase
    end
    // a new event beats a clear in the same cycle
    st_next.stat = (st_reg.stat & ~clr) | ev_i;
    st_next.irq = |(st_next.stat & st_next.mask);
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
      st_reg.en <= tsp_pkg::CTRL_EN_RST;
      st_reg.mask <= tsp_pkg::IRQ_MASK_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wb_ack_o = st_reg.ack;
  assign wb_dat_o = st_reg.dat;
  assign port_en_o = st_reg.en;
  assign irq_o = st_reg.irq;
endmodule
`default_nettype wire

//--- rtl/tsp_spi_port.sv
/*
  four-wire serial slave port: header decode, register and burst access,
  command strobes, status byte return and the ready handshake.
  assumes pins from outside the core clock, and core logic on core_clk_i
  giving read data the cycle after reg_rd_o.
*/
// Implementation choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module tsp_spi_port (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_n_o,
  input wire logic xosc_ok_i,
  input wire logic [2:0] main_state_i,
  input wire logic [3:0] fifo_level_i,
  output logic [5:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [7:0] reg_rdata_i,
  output logic cmd_strobe_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o
);
  typedef struct packed {
    tsp_pkg::tsp_phase_type phase;
    logic [2:0] bit_cnt;
    logic [7:0] rx_sh;
    logic [7:0] tx_sh;
    logic [7:0] rd_buf;
    logic [7:0] hdr;
    logic [5:0] addr;
    logic is_read;
    logic is_burst;
    logic fresh;
    logic boundary;
    logic rd_pend;
    logic sclk_q;
    logic cs_q;
    logic so;
    logic so_oe_n;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic strobe;
    logic [tsp_pkg::EV_W-1:0] ev;
  } tsp_port_type;
  tsp_port_type st_reg;
  tsp_port_type st_next;

  logic cs_l;
  logic sclk_l;
  logic si_l;
  logic port_en;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic [7:0] status;
  logic [7:0] byte_in;
  logic [7:0] load;
  logic [15:0] view;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  tsp_sync #(.RST_VAL(1'b1)) u_cs (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(cs_n_i),
    .level_o(cs_l)
  );
  tsp_sync #(.RST_VAL(1'b0)) u_sclk (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(sclk_i),
    .level_o(sclk_l)
  );
  tsp_sync #(.RST_VAL(1'b0)) u_si (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(si_i),
    .level_o(si_l)
  );

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  assign view = {st_reg.hdr, 5'h00, ~st_reg.cs_q, st_reg.phase};

  tsp_wb_regs u_regs (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .ev_i(st_reg.ev),
    .view_i(view),
    .port_en_o(port_en),
    .irq_o(irq_o)
  );

  // ----------------------------------------------------------------
  // serial engine
  // ----------------------------------------------------------------
  function automatic logic in_strobe_range(input logic [5:0] a);
    in_strobe_range = (a >= tsp_pkg::STROBE_LO) && (a <= tsp_pkg::STROBE_HI);
  endfunction

  assign cs_fall = st_reg.cs_q & ~cs_l;
  assign cs_rise = ~st_reg.cs_q & cs_l;
  assign sclk_rise = ~st_reg.sclk_q & sclk_l;
  assign sclk_fall = st_reg.sclk_q & ~sclk_l;
  assign status = {~xosc_ok_i, main_state_i, fifo_level_i};
  assign byte_in = {st_reg.rx_sh[6:0], si_l};
  // read data bytes carry register contents, all other bytes carry status
  assign load = (st_reg.phase == tsp_pkg::PH_DATA && st_reg.is_read) ?
                st_reg.rd_buf : status;

  always_comb begin
    st_next = st_reg;
    st_next.reg_wr = 1'b0;
    st_next.reg_rd = 1'b0;
    st_next.strobe = 1'b0;
    st_next.ev = '0;
    // backend answers the cycle after the read pulse, so capture one cycle later
    st_next.rd_pend = st_reg.reg_rd;
    st_next.sclk_q = sclk_l;
    st_next.cs_q = cs_l;
    if (st_reg.rd_pend) begin
      st_next.rd_buf = reg_rdata_i;
    end
    case (st_reg.phase)
      tsp_pkg::PH_IDLE: begin
        st_next.so = 1'b1;
        st_next.so_oe_n = 1'b1;
        // drive at once; the ready bit stays high until the oscillator runs
        if (cs_fall && port_en) begin
          st_next.phase = tsp_pkg::PH_HDR;
          st_next.bit_cnt = 3'h0;
          st_next.tx_sh = status;
          st_next.so = status[tsp_pkg::STAT_RDY_BIT];
          st_next.so_oe_n = 1'b0;
          st_next.fresh = 1'b1;
          st_next.boundary = 1'b0;
        end
      end
      tsp_pkg::PH_HDR, tsp_pkg::PH_DATA: begin
        if (cs_l) begin
          // partial bytes never reach the register side
          st_next.phase = tsp_pkg::PH_IDLE;
          st_next.so = 1'b1;
          st_next.so_oe_n = 1'b1;
          st_next.ev[tsp_pkg::EV_ABORT_BIT] = (st_reg.bit_cnt != 3'h0);
        end else begin
          // keep the waiting status live so ready shows when it comes
          if (st_reg.fresh && st_reg.bit_cnt == 3'h0 &&
              st_reg.phase == tsp_pkg::PH_HDR) begin
            st_next.tx_sh = status;
            st_next.so = status[tsp_pkg::STAT_RDY_BIT];
          end
          if (sclk_rise) begin
            st_next.rx_sh = byte_in;
            st_next.bit_cnt = 3'(st_reg.bit_cnt + 3'h1);
            st_next.fresh = 1'b0;
            if (st_reg.bit_cnt == tsp_pkg::BIT_LAST) begin
              st_next.boundary = 1'b1;
              if (st_reg.phase == tsp_pkg::PH_HDR) begin
                st_next.hdr = byte_in;
                st_next.is_read = byte_in[tsp_pkg::HDR_RW_BIT];
                st_next.is_burst = byte_in[tsp_pkg::HDR_BURST_BIT];
                st_next.addr = byte_in[5:0];
                st_next.reg_addr = byte_in[5:0];
                st_next.ev[tsp_pkg::EV_DONE_BIT] = 1'b1;
                if (in_strobe_range(byte_in[5:0]) &&
                    !byte_in[tsp_pkg::HDR_BURST_BIT]) begin
                  st_next.strobe = 1'b1;
                  st_next.ev[tsp_pkg::EV_STROBE_BIT] = 1'b1;
                end else begin
                  st_next.phase = tsp_pkg::PH_DATA;
                  if (byte_in[tsp_pkg::HDR_RW_BIT]) begin
                    st_next.reg_rd = 1'b1;
                  end
                end
              end else begin
                // status registers are read-only and never burst
                if (!st_reg.is_read && !in_strobe_range(st_reg.addr)) begin
                  st_next.reg_wr = 1'b1;
                  st_next.reg_wdata = byte_in;
                  st_next.reg_addr = st_reg.addr;
                end
                if (st_reg.is_burst && !in_strobe_range(st_reg.addr)) begin
                  st_next.addr = 6'(st_reg.addr + 6'h01);
                  if (st_reg.is_read) begin
                    st_next.reg_addr = 6'(st_reg.addr + 6'h01);
                    st_next.reg_rd = 1'b1;
                  end
                end else begin
                  st_next.phase = tsp_pkg::PH_HDR;
                end
              end
            end
          end
          if (sclk_fall) begin
            if (st_reg.boundary) begin
              st_next.tx_sh = load;
              st_next.so = load[7];
              st_next.boundary = 1'b0;
              st_next.fresh = 1'b1;
            end else begin
              st_next.tx_sh = {st_reg.tx_sh[6:0], 1'b0};
              st_next.so = st_reg.tx_sh[6];
            end
          end
        end
      end
      default: begin
        st_next.phase = tsp_pkg::PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
      st_reg.phase <= tsp_pkg::PH_IDLE;
      st_reg.cs_q <= 1'b1;
      st_reg.so <= 1'b1;
      st_reg.so_oe_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign so_o = st_reg.so;
  assign so_oe_n_o = st_reg.so_oe_n;
  assign reg_addr_o = st_reg.reg_addr;
  assign reg_wdata_o = st_reg.reg_wdata;
  assign reg_wr_o = st_reg.reg_wr;
  assign reg_rd_o = st_reg.reg_rd;
  assign cmd_strobe_o = st_reg.strobe;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  cs_release_a: assert property (cs_rise && st_reg.phase != tsp_pkg::PH_IDLE |=>
    st_reg.phase == tsp_pkg::PH_IDLE && so_oe_n_o ##1 so_oe_n_o)
    else $error("port kept driving after chip select rose");
  abort_nowrite_a: assert property (cs_l && st_reg.bit_cnt != 3'h0 &&
    st_reg.phase != tsp_pkg::PH_IDLE |=> !reg_wr_o && !reg_rd_o && !cmd_strobe_o)
    else $error("cancelled byte reached the register side");
  ready_low_a: assert property (st_reg.phase == tsp_pkg::PH_HDR && st_reg.fresh &&
    st_reg.bit_cnt == 3'h0 && !so_oe_n_o && !so_o |-> $past(xosc_ok_i))
    else $error("ready shown without a running oscillator");
  drive_at_cs_a: assert property (st_reg.phase == tsp_pkg::PH_IDLE && cs_fall &&
    port_en |=> !so_oe_n_o && so_o == !$past(xosc_ok_i))
    else $error("serial out not driven after chip select fell");
  status_byte_a: assert property (st_reg.phase == tsp_pkg::PH_IDLE && cs_fall &&
    port_en |=> st_reg.tx_sh == {!$past(xosc_ok_i), $past(main_state_i), $past(fifo_level_i)})
    else $error("status byte layout wrong");
  read_data_a: assert property (sclk_fall && !cs_l && st_reg.boundary &&
    st_reg.phase == tsp_pkg::PH_DATA && st_reg.is_read |=> so_o == $past(st_reg.rd_buf[7]))
    else $error("read byte does not carry register data");
  burst_step_a: assert property (sclk_rise && !cs_l && st_reg.bit_cnt == 3'h7 &&
    st_reg.phase == tsp_pkg::PH_DATA && st_reg.is_burst && !in_strobe_range(st_reg.addr)
    |=> st_reg.addr == 6'($past(st_reg.addr) + 6'h01) && st_reg.phase == tsp_pkg::PH_DATA)
    else $error("burst address did not step by one");
  strobe_pick_a: assert property (reg_wr_o |-> !in_strobe_range(reg_addr_o))
    else $error("write reached a read-only status address");
  strobe_pulse_a: assert property (cmd_strobe_o |-> in_strobe_range(reg_addr_o) &&
    !st_reg.hdr[tsp_pkg::HDR_BURST_BIT] ##1 !cmd_strobe_o)
    else $error("strobe outside its range or longer than one cycle");
  header_msb_a: assert property (sclk_rise && !cs_l && st_reg.bit_cnt == 3'h7 &&
    st_reg.phase == tsp_pkg::PH_HDR |=> st_reg.hdr == {$past(st_reg.rx_sh[6:0]), $past(si_l)})
    else $error("header not assembled msb first");
  so_on_fall_a: assert property ($changed(so_o) && !so_oe_n_o && !$past(so_oe_n_o) &&
    !$past(st_reg.fresh) |-> $past(sclk_fall))
    else $error("serial out moved off a falling edge");

  burst_write_c: cover property (reg_wr_o ##[1:200] reg_wr_o);
  burst_read_c: cover property (reg_rd_o && st_reg.is_burst ##[1:200] reg_rd_o);
  strobe_c: cover property (cmd_strobe_o);
  abort_c: cover property (st_reg.ev[tsp_pkg::EV_ABORT_BIT]);
endmodule
`default_nettype wire

//--- verif/tsp_host_model.sv
/*
  host side serial master model for the configuration port bench.
  assumes so_i is the resolved line, pulled high when not driven.
*/
`timescale 1ns/1ps
`default_nettype none
module tsp_host_model (
  input wire logic so_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic si_o,
  output logic [7:0] rx_byte_o,
  output logic [15:0] rx_cnt_o
);
  // ------------------------------------------------------------
  // link clock only toggles inside frames
  // ------------------------------------------------------------
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    si_o = 1'b0;
    rx_byte_o = 8'h00;
    rx_cnt_o = 16'h0000;
  end
  task automatic cs_fall();
    cs_n_o = 1'b0;
  endtask
  // bound covers the power-down wake wait
  task automatic wait_ready(output bit ok);
    int n;
    n = 0;
    while (so_i !== 1'b0 && n < 20000) begin
      #8;
      n++;
    end
    ok = (n < 20000);
  endtask
  // so is taken late, just before the device moves it again
  task automatic shift(input logic [7:0] tx, input int nbits);
    logic [7:0] rx;
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      si_o = tx[i];
      #40 sclk_o = 1'b1;
      #40 rx[i] = so_i;
      sclk_o = 1'b0;
    end
    if (nbits == 8) begin
      rx_byte_o = rx;
      rx_cnt_o = rx_cnt_o + 16'h0001;
    end
    #120;
  endtask
  task automatic cs_rise();
    #40 cs_n_o = 1'b1;
    si_o = ~si_o;
    #400;
  endtask
endmodule
`default_nettype wire

//--- verif/transceiver_spi_config_port_tb_top.sv
/*
  self-checking bench for the serial configuration port.
  assumes the host model and a one-cycle read backend modelled here.
*/
`timescale 1ns/1ps
`default_nettype none
module transceiver_spi_config_port_tb_top;
  logic core_clk_i, rst_n_i, cs_n, sclk, si, so, so_oe_n, xosc_ok, reg_wr, reg_rd;
  logic cmd_strobe, wb_cyc, wb_stb, wb_we, wb_ack, irq, so_line;
  logic [2:0] main_state;
  logic [3:0] fifo_level, wb_sel;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, wb_adr, rx_byte, salt;
  logic [7:0] reg_rdata = 8'h00;
  logic [15:0] rx_cnt, rx_seen;
  logic [31:0] wb_dat_w, wb_dat_r;
  logic [31:0] exp_q[3][$];
  int mismatches, samples_checked;
  assign so_line = so_oe_n ? 1'b1 : so;
  tsp_spi_port dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n),
    .sclk_i(sclk), .si_i(si), .so_o(so), .so_oe_n_o(so_oe_n), .xosc_ok_i(xosc_ok),
    .main_state_i(main_state), .fifo_level_i(fifo_level), .reg_addr_o(reg_addr),
    .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
    .reg_rdata_i(reg_rdata), .cmd_strobe_o(cmd_strobe), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .irq_o(irq));
  tsp_host_model host (.so_i(so_line), .cs_n_o(cs_n), .sclk_o(sclk), .si_o(si),
    .rx_byte_o(rx_byte), .rx_cnt_o(rx_cnt));
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  // backend lags the address by one cycle, inside the read latency
  always @(posedge core_clk_i) reg_rdata <= {2'b00, reg_addr} ^ salt;
  // ------------------------------------------------------------
  // checking
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic take(input int k, input logic [31:0] got);
    logic [31:0] e;
    e = (exp_q[k].size() > 0) ? exp_q[k].pop_front() : ~got;
    chk(got, e);
  endtask
  always @(negedge core_clk_i) begin
    if (wb_ack === 1'b1 && wb_we === 1'b0) take(0, wb_dat_r);
    if (reg_wr === 1'b1) take(1, {16'h0100, 2'b00, reg_addr, reg_wdata});
    if (cmd_strobe === 1'b1) take(1, {16'h0200, 2'b00, reg_addr, 8'h00});
    if (reg_rd === 1'b1) take(1, {16'h0300, 2'b00, reg_addr, 8'h00});
    if (rx_cnt !== rx_seen) begin
      rx_seen = rx_cnt;
      take(2, {24'h00_0000, rx_byte});
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ------------------------------------------------------------
  // drivers
  // ------------------------------------------------------------
  task automatic wb_go(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk_i);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w, wb_sel} <= {2'b11, we, a, d, 4'hF};
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    {wb_cyc, wb_stb} <= 2'b00;
    if (n >= 20) begin
      mismatches++;
      complete_run();
    end
  endtask
  task automatic wb_rd(input logic [7:0] a, input logic [31:0] e);
    exp_q[0].push_back(e);
    wb_go(1'b0, a, 32'h0000_0000);
  endtask
  task automatic open_frame();
    bit ok;
    host.cs_fall();
    host.wait_ready(ok);
    if (!ok) begin
      mismatches++;
      complete_run();
    end
  endtask
  task automatic frame(input logic rd, input logic bst, input logic [5:0] a, input int n);
    logic [7:0] d;
    logic st;
    @(posedge core_clk_i);
    main_state <= 3'($urandom);
    fifo_level <= 4'($urandom);
    st = (a >= tsp_pkg::STROBE_LO && a <= tsp_pkg::STROBE_HI);
    open_frame();
    exp_q[2].push_back({24'h00_0000, ~xosc_ok, main_state, fifo_level});
    if (st && !bst) exp_q[1].push_back({16'h0200, 2'b00, a, 8'h00});
    if (rd && !(st && !bst)) exp_q[1].push_back({16'h0300, 2'b00, a, 8'h00});
    host.shift({rd, bst, a}, 8);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      if (rd) exp_q[2].push_back({24'h00_0000, {2'b00, a} ^ salt});
      else exp_q[2].push_back({24'h00_0000, ~xosc_ok, main_state, fifo_level});
      if (!rd && !st) exp_q[1].push_back({16'h0100, 2'b00, a, d});
      if (rd && bst && !st) exp_q[1].push_back({16'h0300, 2'b00, 6'(a + 6'h01), 8'h00});
      host.shift(d, 8);
      if (!st) a = a + 6'h01;
    end
    host.cs_rise();
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst_n_i = 1'b0;
    {xosc_ok, main_state, fifo_level, rx_seen} = {1'b1, 7'h00, 16'h0000};
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w, wb_sel} = '0;
    mismatches = 0;
    samples_checked = 0;
    void'($urandom(32'h6b89447f));
    salt = 8'($urandom);
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (10) @(posedge core_clk_i);
    wb_rd(tsp_pkg::CTRL_OFS, 32'h0000_0001);
    wb_rd(tsp_pkg::IRQ_MASK_OFS, 32'h0000_0000);
    wb_rd(8'h40, 32'h0000_0000);
    frame(1'b0, 1'b0, 6'h2A, 1);
    wb_rd(tsp_pkg::STAT_OFS, 32'h0000_2A00);
    frame(1'b1, 1'b0, 6'($urandom_range(47, 0)), 1);
    frame(1'b0, 1'b1, 6'h2D, 3);
    frame(1'b1, 1'b1, 6'h10, 2);
    for (int s = 48; s <= 61; s++) frame(1'($urandom), 1'b0, 6'(s), 0);
    frame(1'b1, 1'b1, 6'h34, 1);
    frame(1'b0, 1'b1, 6'h31, 1);
    open_frame();
    host.shift(8'h85, 4);
    host.cs_rise();
    wb_rd(tsp_pkg::IRQ_STAT_OFS, 32'h0000_0007);
    chk(irq, 1'b0);
    wb_go(1'b1, tsp_pkg::IRQ_MASK_OFS, 32'h0000_0002);
    repeat (2) @(posedge core_clk_i);
    chk(irq, 1'b1);
    wb_go(1'b1, tsp_pkg::IRQ_STAT_OFS, 32'h0000_0007);
    repeat (2) @(posedge core_clk_i);
    chk(irq, 1'b0);
    wb_rd(tsp_pkg::IRQ_STAT_OFS, 32'h0000_0000);
    wb_go(1'b1, tsp_pkg::CTRL_OFS, 32'h0000_0000);
    host.cs_fall();
    repeat (20) @(posedge core_clk_i);
    chk(so_oe_n, 1'b1);
    host.cs_rise();
    wb_go(1'b1, tsp_pkg::CTRL_OFS, 32'h0000_0001);
    xosc_ok <= 1'b0;
    host.cs_fall();
    repeat (40) @(posedge core_clk_i);
    chk(so_line, 1'b1);
    xosc_ok <= 1'b1;
    open_frame();
    host.cs_rise();
    repeat (10) @(posedge core_clk_i);
    for (int k = 0; k < 3; k++) mismatches += exp_q[k].size();
    complete_run();
  end
endmodule
`default_nettype wire
